// *** rtl/sscm_core.v ***
`timescale 1ns/10ps
`default_nettype none
`include "sscm_map.vh"
// Serial command front end and power-mode control
module sscm_core #(
   parameter STARTUP_CYC = `SSCM_STARTUP_CYC,
   parameter WAKE_SLP_CYC = `SSCM_WAKE_SLP_CYC,
   parameter WAKE_STB_CYC = `SSCM_WAKE_STB_CYC,
   parameter SLEEPB_CYC = `SSCM_SLEEPB_CYC
) (
   input wire clk_in,
   input wire rst_n_in,
   input wire spi_cs_n_in,
   input wire spi_sclk_in,
   input wire spi_mosi_in,
   input wire meas_done_in,
   input wire test_mode_in,
   input wire critical_error_in,
   output reg spi_miso_out,
   output reg spi_miso_oe_out,
   output reg measurement_ready_out,
   output reg awake_out,
   output reg chip_reset_pulse_out,
   output reg watchdog_kick_out,
   output reg measure_start_out,
   output reg diag_start_out,
   output reg readout_start_out,
   output reg [6:0] measurement_select_bits_out,
   output reg buffer_offset_invert_out,
   output reg test_pulse_out,
   output reg reg_write_out,
   output reg reg_fetch_out,
   output reg [3:0] register_index_out,
   output reg [7:0] register_payload_out,
   output reg [1:0] register_check_bits_out
);
   // Timer width fits the longest count
   localparam TW = 24;
   // Power states, one-hot
   localparam [2:0] ST_NORMAL = 3'b001;
   localparam [2:0] ST_STANDBY = 3'b010;
   localparam [2:0] ST_SLEEP = 3'b100;

   wire cs_n; // Filtered select
   wire sclk_rise;
   wire sclk_fall;
   wire cs_rise;
   wire cs_fall;
   wire mosi;
   wire [2:0] rise_w;
   wire [2:0] fall_w;
   wire [2:0] lvl_w;

   // Pins cross from the link side through three flops
   // Reset levels match the idle pins, so no false edge follows reset
   sscm_pin_sync #(.WIDTH(3), .INIT(3'b110)) u_sync (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .pin_in({spi_cs_n_in, spi_sclk_in, spi_mosi_in}),
      .level_out(lvl_w),
      .rise_out(rise_w),
      .fall_out(fall_w)
   );
   assign cs_n = lvl_w[2];
   assign cs_rise = rise_w[2];
   assign cs_fall = fall_w[2];
   assign sclk_rise = rise_w[1] & ~cs_n;
   assign sclk_fall = fall_w[1] & ~cs_n;
   assign mosi = lvl_w[0];

   reg [4:0] bit_cnt_q; // Bits taken this frame
   reg [23:0] rx_q; // Last three bytes shifted in
   reg [7:0] tx_q; // Outgoing shift register
   reg [7:0] cmd_q; // Command byte of this frame
   reg [2:0] pwr_q; // One-hot power state
   reg slp_req_q;
   reg stb_req_q;
   reg invalid_q;
   reg busy_q; // Measurement running
   reg [TW-1:0] rdy_cnt_q; // Ready low countdown
   reg [TW-1:0] slp_cnt_q; // Delay to awake low
   reg slp_pend_q;

   // Status byte assembly
   wire [1:0] pwr_code = pwr_q[0] ? `SSCM_PWR_NORMAL :
                         pwr_q[1] ? `SSCM_PWR_STANDBY : `SSCM_PWR_SLEEP;
   wire [7:0] status = {invalid_q, pwr_code, slp_req_q, stb_req_q,
                        test_mode_in, ~pwr_q[2], critical_error_in};

   // True for three-byte opcodes
   function is_long;
      input [7:0] op;
      begin
         is_long = (op == `SSCM_OP_REG_WR) || (op == `SSCM_OP_REG_RD);
      end
   endfunction

   // Even parity over all eight bits of the argument
   function par_ok;
      input [7:0] arg;
      begin
         par_ok = ~^arg;
      end
   endfunction

   // Command byte captured at bit 8; argument position follows frame length
   wire [7:0] c = cmd_q;
   wire long_frame = (bit_cnt_q == 5'd24);
   wire [7:0] a = long_frame ? rx_q[15:8] : rx_q[7:0];
   wire [7:0] a3 = rx_q[7:0];
   wire full_frame = is_long(c) ? (bit_cnt_q == 5'd24) : (bit_cnt_q == 5'd16);
   wire exec = cs_rise & full_frame & c[7];

   // Serial shift and response
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         bit_cnt_q <= 5'd0;
         rx_q <= 24'h000000;
         tx_q <= 8'h00;
         cmd_q <= 8'h00;
         spi_miso_out <= 1'b0;
         spi_miso_oe_out <= 1'b0;
      end else begin
         spi_miso_oe_out <= ~cs_n;
         if (cs_n) begin
            bit_cnt_q <= 5'd0;
         end
         if (cs_fall) begin
            tx_q <= status;
            spi_miso_out <= status[7];
         end
         if (sclk_rise && bit_cnt_q != 5'd24) begin
            rx_q <= {rx_q[22:0], mosi};
            bit_cnt_q <= bit_cnt_q + 5'd1;
            if (bit_cnt_q == 5'd7) begin
               cmd_q <= {rx_q[6:0], mosi};
            end
         end
         if (sclk_fall) begin
            // Echo loaded at byte boundary, else shift
            if (bit_cnt_q == 5'd0) begin
               // First fall presents the status MSB; a shift here would drop it
               tx_q <= status;
               spi_miso_out <= status[7];
            end else if (bit_cnt_q == 5'd8) begin
               tx_q <= cmd_q;
               spi_miso_out <= cmd_q[7];
            end else begin
               tx_q <= {tx_q[6:0], 1'b0};
               spi_miso_out <= tx_q[6];
            end
         end
      end
   end

   // Command decode, power modes and ready pin
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         pwr_q <= ST_NORMAL;
         slp_req_q <= 1'b0;
         stb_req_q <= 1'b0;
         invalid_q <= 1'b0;
         busy_q <= 1'b0;
         rdy_cnt_q <= STARTUP_CYC;
         slp_cnt_q <= {TW{1'b0}};
         slp_pend_q <= 1'b0;
         measurement_ready_out <= 1'b0;
         awake_out <= 1'b1;
         chip_reset_pulse_out <= 1'b0;
         watchdog_kick_out <= 1'b0;
         measure_start_out <= 1'b0;
         diag_start_out <= 1'b0;
         readout_start_out <= 1'b0;
         measurement_select_bits_out <= 7'h00;
         buffer_offset_invert_out <= 1'b0;
         test_pulse_out <= 1'b0;
         reg_write_out <= 1'b0;
         reg_fetch_out <= 1'b0;
         register_index_out <= 4'h0;
         register_payload_out <= 8'h00;
         register_check_bits_out <= 2'b00;
      end else begin
         chip_reset_pulse_out <= 1'b0;
         watchdog_kick_out <= 1'b0;
         measure_start_out <= 1'b0;
         diag_start_out <= 1'b0;
         readout_start_out <= 1'b0;
         reg_write_out <= 1'b0;
         reg_fetch_out <= 1'b0;
         // Ready countdown, then wait for the measurement
         if (rdy_cnt_q != {TW{1'b0}}) begin
            rdy_cnt_q <= rdy_cnt_q - {{(TW-1){1'b0}}, 1'b1};
         end else if (!busy_q) begin
            measurement_ready_out <= 1'b1;
         end
         if (busy_q && meas_done_in) begin
            busy_q <= 1'b0;
         end
         // Awake indicator drops a delay after confirm
         if (slp_pend_q) begin
            if (slp_cnt_q == {TW{1'b0}}) begin
               slp_pend_q <= 1'b0;
               awake_out <= 1'b0;
            end else begin
               slp_cnt_q <= slp_cnt_q - {{(TW-1){1'b0}}, 1'b1};
            end
         end
         if (exec) begin
            if (c == `SSCM_OP_RESET && a == 8'h00) begin
               // Accepted in every state; pulses the reset line, watchdog untouched
               pwr_q <= ST_NORMAL;
               slp_req_q <= 1'b0;
               stb_req_q <= 1'b0;
               busy_q <= 1'b0;
               invalid_q <= 1'b0;
               slp_pend_q <= 1'b0;
               awake_out <= 1'b1;
               chip_reset_pulse_out <= 1'b1;
               measurement_ready_out <= 1'b0;
               rdy_cnt_q <= STARTUP_CYC[TW-1:0];
            end else if (busy_q || !measurement_ready_out) begin
               invalid_q <= 1'b1;
            end else begin
               invalid_q <= 1'b0;
               case (1'b1)
                  (c == `SSCM_OP_WDOG && a == 8'h00 && !pwr_q[2]): begin
                     watchdog_kick_out <= 1'b1;
                  end
                  (c == `SSCM_OP_SLP_REQ && a == 8'h00): begin
                     slp_req_q <= 1'b1;
                  end
                  (c == `SSCM_OP_SLP_CONF && a == 8'h00 && slp_req_q): begin
                     // Request flag stays until chip reset or normal command
                     pwr_q <= ST_SLEEP;
                     slp_pend_q <= 1'b1;
                     slp_cnt_q <= SLEEPB_CYC[TW-1:0];
                  end
                  (c == `SSCM_OP_STB_REQ && a == 8'h00 && pwr_q[0]): begin
                     stb_req_q <= 1'b1;
                  end
                  (c == `SSCM_OP_STB_CONF && a == 8'h00 && stb_req_q): begin
                     pwr_q <= ST_STANDBY;
                     slp_pend_q <= 1'b1;
                     slp_cnt_q <= SLEEPB_CYC[TW-1:0];
                  end
                  (c == `SSCM_OP_NORMAL && a == 8'h00): begin
                     slp_req_q <= 1'b0;
                     stb_req_q <= 1'b0;
                     if (!pwr_q[0]) begin
                        // Wake: ready low for the wake delay
                        pwr_q <= ST_NORMAL;
                        awake_out <= 1'b1;
                        slp_pend_q <= 1'b0;
                        measurement_ready_out <= 1'b0;
                        rdy_cnt_q <= pwr_q[2] ? WAKE_SLP_CYC[TW-1:0] :
                                     WAKE_STB_CYC[TW-1:0];
                     end
                  end
                  (c == `SSCM_OP_DIAG && a == 8'h00 && pwr_q[0]): begin
                     diag_start_out <= 1'b1;
                     busy_q <= 1'b1;
                     measurement_ready_out <= 1'b0;
                  end
                  (c == `SSCM_OP_READOUT && a == 8'h00 && pwr_q[0]): begin
                     readout_start_out <= 1'b1;
                  end
                  ((c & `SSCM_OP_MEAS_MASK) == `SSCM_OP_MEAS && pwr_q[0]): begin
                     if (par_ok(a)) begin
                        measure_start_out <= 1'b1;
                        buffer_offset_invert_out <= c[1];
                        test_pulse_out <= c[0];
                        measurement_select_bits_out <= a[7:1];
                        busy_q <= 1'b1;
                        measurement_ready_out <= 1'b0;
                     end else begin
                        invalid_q <= 1'b1;
                     end
                  end
                  (c == `SSCM_OP_REG_WR && a3[1:0] == 2'b00 && pwr_q[0]): begin
                     reg_write_out <= 1'b1;
                     register_payload_out <= a;
                     register_index_out <= a3[7:4];
                     register_check_bits_out <= a3[3:2];
                  end
                  (c == `SSCM_OP_REG_RD && a[3:0] == 4'h0 && a3 == 8'h00 && pwr_q[0]): begin
                     reg_fetch_out <= 1'b1;
                     register_index_out <= a[7:4];
                  end
                  default: begin
                     invalid_q <= 1'b1;
                  end
               endcase
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** rtl/sscm_map.vh ***
`ifndef SSCM_MAP_VH
`define SSCM_MAP_VH
// Opcodes
`define SSCM_OP_IDLE 8'h00
`define SSCM_OP_RESET 8'hf0
`define SSCM_OP_WDOG 8'h93
`define SSCM_OP_SLP_REQ 8'he1
`define SSCM_OP_SLP_CONF 8'ha3
`define SSCM_OP_STB_REQ 8'he2
`define SSCM_OP_STB_CONF 8'ha6
`define SSCM_OP_NORMAL 8'he4
`define SSCM_OP_DIAG 8'hb0
`define SSCM_OP_READOUT 8'hc3
`define SSCM_OP_REG_WR 8'h87
`define SSCM_OP_REG_RD 8'h8e
`define SSCM_OP_MEAS_MASK 8'hfc
`define SSCM_OP_MEAS 8'hd0
// Status byte fields
`define SSCM_ST_INVALID 7
`define SSCM_ST_PWR_HI 6
`define SSCM_ST_PWR_LO 5
`define SSCM_ST_SLP_REQ 4
`define SSCM_ST_STB_REQ 3
`define SSCM_ST_TEST 2
`define SSCM_ST_OSC 1
`define SSCM_ST_ERR 0
// Power codes
`define SSCM_PWR_NORMAL 2'b10
`define SSCM_PWR_STANDBY 2'b01
`define SSCM_PWR_SLEEP 2'b00
// Timing, in microseconds and cycles at 100 MHz
`define SSCM_CLK_MHZ 100
`define SSCM_T_STARTUP_US 100
`define SSCM_T_WAKE_SLP_US 50
`define SSCM_T_WAKE_STB_US 20
`define SSCM_T_SLEEPB_US 1
`define SSCM_STARTUP_CYC (`SSCM_T_STARTUP_US * `SSCM_CLK_MHZ)
`define SSCM_WAKE_SLP_CYC (`SSCM_T_WAKE_SLP_US * `SSCM_CLK_MHZ)
`define SSCM_WAKE_STB_CYC (`SSCM_T_WAKE_STB_US * `SSCM_CLK_MHZ)
`define SSCM_SLEEPB_CYC (`SSCM_T_SLEEPB_US * `SSCM_CLK_MHZ)
`endif

// *** rtl/sscm_pin_sync.v ***
`timescale 1ns/10ps
`default_nettype none
// Three-stage synchroniser; stage 1 feeds stage 2 only
module sscm_pin_sync #(
   parameter WIDTH = 3,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
   input wire clk_in,
   input wire rst_n_in,
   input wire [WIDTH-1:0] pin_in,
   output wire [WIDTH-1:0] level_out,
   output wire [WIDTH-1:0] rise_out,
   output wire [WIDTH-1:0] fall_out
);
   reg [WIDTH-1:0] s1_q; // Metastable stage
   reg [WIDTH-1:0] s2_q; // Second stage
   reg [WIDTH-1:0] s3_q; // Third stage
   reg [WIDTH-1:0] lvl_q; // Accepted level

   // Shift chain
   always @(posedge clk_in) begin
      if (!rst_n_in) begin
         s1_q <= INIT;
         s2_q <= INIT;
         s3_q <= INIT;
      end else begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // Level changes only when stages 2 and 3 agree
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge clk_in) begin
            if (!rst_n_in) begin
               lvl_q[i] <= INIT[i];
            end else if (s2_q[i] == s3_q[i]) begin
               lvl_q[i] <= s3_q[i];
            end
         end
         assign rise_out[i] = (s2_q[i] == s3_q[i]) & s3_q[i] & ~lvl_q[i];
         assign fall_out[i] = (s2_q[i] == s3_q[i]) & ~s3_q[i] & lvl_q[i];
      end
   endgenerate

   assign level_out = lvl_q;
endmodule
`default_nettype wire

// *** tb/sscm_core_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
// Pin-level checks on the serial command core
module sscm_chk (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic spi_cs_n_in,
   input wire logic spi_sclk_in,
   input wire logic spi_miso_out,
   input wire logic spi_miso_oe_out,
   input wire logic measurement_ready_out,
   input wire logic awake_out,
   input wire logic chip_reset_pulse_out,
   input wire logic watchdog_kick_out,
   input wire logic measure_start_out,
   input wire logic diag_start_out,
   input wire logic readout_start_out,
   input wire logic reg_write_out,
   input wire logic reg_fetch_out
);
   // All command pulses together
   wire logic [6:0] pul = {chip_reset_pulse_out, watchdog_kick_out, measure_start_out,
      diag_start_out, readout_start_out, reg_write_out, reg_fetch_out};
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);
   // Six cycles cover the pin synchroniser lag
   a_oe_released: assert property (
      spi_cs_n_in [*6] |-> !spi_miso_oe_out) else $error("miso driven while deselected");
   a_oe_driven: assert property (
      !spi_cs_n_in [*6] |-> spi_miso_oe_out) else $error("miso idle while selected");
   // Data moves only after a falling serial clock or a falling select
   a_miso_steady: assert property (
      (!spi_cs_n_in && spi_sclk_in) [*2] |-> $stable(spi_miso_out))
      else $error("miso moved while serial clock high");
   a_pulse_onehot: assert property (
      $onehot0(pul)) else $error("two command pulses at once");
   // Commands run only once the frame is closed
   a_pulse_framed: assert property (
      |pul |-> spi_cs_n_in ##1 !spi_miso_oe_out) else $error("command inside a frame");
   a_reset_ready: assert property (
      chip_reset_pulse_out |=> !measurement_ready_out [*8]) else $error("ready high after reset");
   a_reset_awake: assert property (
      chip_reset_pulse_out |-> ##[0:1] awake_out) else $error("reset left device asleep");
   a_start_ready: assert property (
      (measure_start_out || diag_start_out) |-> $past(measurement_ready_out))
      else $error("start taken while not ready");
   a_sleep_delay: assert property (
      $fell(awake_out) |-> $past(spi_cs_n_in, 8) && measurement_ready_out)
      else $error("awake fell early or ready moved");
   a_wake_ready: assert property (
      $rose(awake_out) |=> !measurement_ready_out [*4]) else $error("ready high during wake");
endmodule
bind sscm_core sscm_chk chk_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
   .spi_cs_n_in(spi_cs_n_in), .spi_sclk_in(spi_sclk_in), .spi_miso_out(spi_miso_out),
   .spi_miso_oe_out(spi_miso_oe_out), .measurement_ready_out(measurement_ready_out),
   .awake_out(awake_out), .chip_reset_pulse_out(chip_reset_pulse_out),
   .watchdog_kick_out(watchdog_kick_out), .measure_start_out(measure_start_out),
   .diag_start_out(diag_start_out), .readout_start_out(readout_start_out),
   .reg_write_out(reg_write_out), .reg_fetch_out(reg_fetch_out));
`default_nettype wire

// *** tb/sscm_host.sv ***
`timescale 1ns/10ps
`default_nettype none
// Host side of the serial link, 80 ns serial clock
module sscm_host (
   input wire logic clk_in,
   input wire logic miso_in,
   output var logic cs_n_out,
   output var logic sclk_out,
   output var logic mosi_out
);
   // Idle levels
   initial begin
      cs_n_out = 1'b1;
      sclk_out = 1'b1;
      mosi_out = 1'b0;
   end
   // One frame; clock runs only inside it
   task automatic xfer(input logic [23:0] tx, input bit three, output logic [23:0] rx);
      rx = '0;
      @(negedge clk_in);
      cs_n_out = 1'b0;
      #40;
      for (int i = 0; i < (three ? 24 : 16); i++) begin
         sclk_out = 1'b0;
         mosi_out = tx[23-i];
         #40;
         sclk_out = 1'b1;
         rx[23-i] = miso_in;
         #40;
      end
      // Hold past the last edge, then deselect for the gap
      #40;
      cs_n_out = 1'b1;
      mosi_out = 1'b0;
      repeat (16) @(negedge clk_in);
   endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
// Bench: host model drives commands, state model predicts replies
module tb;
   logic clk_in, rst_n_in, meas_done_in, test_mode_in, critical_error_in;
   wire cs_n, sclk, mosi, miso, oe, miso_w, ready, awake, inv, tp;
   wire [6:0] pul; // Reset, kick, measure, diag, readout, write, fetch
   wire [6:0] msel;
   wire [3:0] ridx;
   wire [7:0] rpay;
   wire [1:0] rchk;
   int failures, n_checks, cyc, seed = 20548;
   int cnt[7], ecnt[7];
   logic [1:0] pwr; // Expected power code
   logic sreq, breq, invd, rdy;
   assign miso_w = oe ? miso : 1'bz;
   sscm_core #(.STARTUP_CYC(30), .WAKE_SLP_CYC(40), .WAKE_STB_CYC(25), .SLEEPB_CYC(5)) dut_u (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .spi_cs_n_in(cs_n), .spi_sclk_in(sclk),
      .spi_mosi_in(mosi), .meas_done_in(meas_done_in), .test_mode_in(test_mode_in),
      .critical_error_in(critical_error_in), .spi_miso_out(miso), .spi_miso_oe_out(oe),
      .measurement_ready_out(ready), .awake_out(awake), .chip_reset_pulse_out(pul[6]),
      .watchdog_kick_out(pul[5]), .measure_start_out(pul[4]), .diag_start_out(pul[3]),
      .readout_start_out(pul[2]), .reg_write_out(pul[1]), .reg_fetch_out(pul[0]),
      .measurement_select_bits_out(msel), .buffer_offset_invert_out(inv),
      .test_pulse_out(tp), .register_index_out(ridx),
      .register_payload_out(rpay), .register_check_bits_out(rchk));
   sscm_host host_u (.clk_in(clk_in), .miso_in(miso_w), .cs_n_out(cs_n), .sclk_out(sclk),
      .mosi_out(mosi));
   initial begin
      clk_in = 0;
      forever #5 clk_in = ~clk_in;
   end
   // Pulse counters and hang guard
   always @(posedge clk_in) begin
      cyc++;
      for (int i = 0; i < 7; i++)
         if (pul[i] === 1'b1) cnt[i]++;
      if (cyc == 40000) begin
         failures++;
         final_report();
      end
   end
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic final_report();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Bounded wait for the ready pin
   task automatic wait_rdy();
      for (int k = 0; k < 300 && ready !== 1'b1; k++) @(negedge clk_in);
      rdy = 1;
   endtask
   task automatic done();
      @(negedge clk_in);
      meas_done_in = 1;
      @(negedge clk_in);
      meas_done_in = 0;
      wait_rdy();
   endtask
   // One command: send, compare replies, then advance the model
   task automatic cmd(input logic [7:0] op, input logic [7:0] arg = 8'h00,
         input logic [7:0] a2 = 8'h00, input bit three = 0);
      logic [23:0] rx;
      logic [7:0] st;
      int p;
      bit wk;
      @(negedge clk_in);
      test_mode_in = $random(seed);
      critical_error_in = $random(seed);
      st = {invd, pwr, sreq, breq, test_mode_in, pwr != 2'b00, critical_error_in};
      host_u.xfer({op, arg, a2}, three, rx);
      chk("status", st, rx[23:16]);
      chk("echo", op, rx[15:8]);
      p = -1;
      wk = 0;
      if (op[7] && three == (op == 8'h87 || op == 8'h8e)) begin
         if (op == 8'hf0) begin
            p = 6;
            wk = 1;
            pwr = 2;
            sreq = 0;
            breq = 0;
         end else if (rdy) begin
            case (op)
               8'h93: if (arg == 0 && pwr != 0) p = 5;
               8'he1: if (arg == 0) p = 7;
               8'ha3: if (arg == 0 && sreq) p = 7;
               8'he2: if (arg == 0 && pwr == 2) p = 7;
               8'ha6: if (arg == 0 && breq) p = 7;
               8'he4: if (arg == 0) p = 7;
               8'hb0: if (arg == 0 && pwr == 2) p = 3;
               8'hc3: if (arg == 0 && pwr == 2) p = 2;
               8'h87: if (a2[1:0] == 0 && pwr == 2) p = 1;
               8'h8e: if (a2 == 0 && arg[3:0] == 0 && pwr == 2) p = 0;
               default: if (op[7:2] == 6'h34 && pwr == 2 && ^arg == 1'b0) p = 4;
            endcase
            // Mode effects of the handshakes
            if (p == 7) begin
               sreq = sreq | op == 8'he1;
               breq = breq | op == 8'he2;
               wk = op == 8'he4 && pwr != 2;
               pwr = op == 8'ha3 ? 2'b00 : op == 8'ha6 ? 2'b01 : op == 8'he4 ? 2'b10 : pwr;
               sreq = sreq & op != 8'he4;
               breq = breq & op != 8'he4;
            end
         end
         invd = p < 0 && op != 8'hf0;
      end
      if (p >= 0 && p < 7) ecnt[p]++;
      if (p == 3 || p == 4 || wk) rdy = 0;
      chk("ready", rdy, ready);
      chk("awake", pwr == 2, awake);
      for (int i = 0; i < 7; i++) chk("pulse", 16'(ecnt[i]), 16'(cnt[i]));
      if (p == 4) chk("measure", {op[1:0], arg[7:1]}, {inv, tp, msel});
      if (p == 1) chk("write", {a2[7:2], arg}, {ridx, rchk, rpay});
      if (p == 0) chk("fetch", arg[7:4], ridx);
      if (wk) wait_rdy();
   endtask
   initial begin
      logic [7:0] a;
      rst_n_in = 0;
      meas_done_in = 0;
      test_mode_in = 0;
      critical_error_in = 0;
      pwr = 2;
      {sreq, breq, invd, rdy} = 0;
      repeat (6) @(negedge clk_in);
      rst_n_in = 1;
      chk("ready", 0, ready);
      wait_rdy();
      cmd(8'h00);
      cmd(8'h93);
      cmd(8'hc3);
      cmd(8'hb0);
      cmd(8'h93);
      done();
      for (int i = 0; i < 4; i++) begin
         a = $random(seed);
         a[6:5] = 0;
         a[0] = ^a[7:1] ^ (i == 3);
         cmd(8'hd0 | 8'(i), a);
         if (i < 3) done();
      end
      cmd(8'h87, 8'h3c, 8'h50, 1);
      cmd(8'h8e, 8'ha0, 8'h00, 1);
      cmd(8'h87, 8'h3c);
      cmd(8'h33);
      cmd(8'hff);
      cmd(8'h93, 8'h01);
      cmd(8'he2);
      cmd(8'ha6);
      cmd(8'hd1, 8'h81);
      cmd(8'he4);
      cmd(8'he1);
      cmd(8'ha3);
      cmd(8'he4);
      cmd(8'he1);
      cmd(8'he4);
      cmd(8'he1);
      cmd(8'ha3);
      cmd(8'hf0);
      cmd(8'hd0, 8'h81);
      cmd(8'h93);
      cmd(8'hf0);
      cmd(8'h00);
      final_report();
   end
endmodule
`default_nettype wire
